// file: shared/rxqc_pkg.sv
// Purpose: constants for the receive queue command and control register
// Assumes: 16-bit register, word access only, 50 MHz clock
// Notes: layout and reset value of the register, offsets of its neighbours
//
// Notes on behaviour
// - Bit 12 shows interrupt was caused by duration timer over threshold.
// - Bit 11 shows interrupt was caused by buffered bytes over threshold.
// - Bit 10 shows interrupt was caused by buffered frames over threshold.
// - Status bits 12..10 refresh only on write one to interrupt bit 13.
// - Bit 9 set pads two bytes before each frame header.
// - Bit 7 enables receive interrupt from duration timer threshold.
// - Bit 6 enables receive interrupt from byte count threshold.
// - Bit 5 enables receive interrupt from frame count threshold.
// - Bit 4 dequeues frame automatically once host has read it fully.
// - While DMA window is open only this register is accessible.
// - Bit 0 releases current errored frame; clears itself when done.
// - Duration threshold counts one-microsecond steps, largest value 0xCFFF.

package rxqc_pkg;
   localparam logic [7:0] RXQC_CMD_OFFSET = 8'h82;
   localparam logic [7:0] RXQC_ISR_OFFSET = 8'h92;
   localparam logic [7:0] RXQC_DTT_OFFSET = 8'h8C;
   localparam logic [7:0] RXQC_DBCT_OFFSET = 8'h8E;
   localparam logic [7:0] RXQC_FCT_OFFSET = 8'h9C;
   localparam int RXQC_ISR_RX_BIT = 13;
   localparam int RXQC_DUR_HIT_BIT = 12;
   localparam int RXQC_BYTE_HIT_BIT = 11;
   localparam int RXQC_FRAME_HIT_BIT = 10;
   localparam int RXQC_PAD_BIT = 9;
   localparam int RXQC_DUR_EN_BIT = 7;
   localparam int RXQC_BYTE_EN_BIT = 6;
   localparam int RXQC_FRAME_EN_BIT = 5;
   localparam int RXQC_AUTO_DEQ_BIT = 4;
   localparam int RXQC_DMA_BIT = 3;
   localparam int RXQC_RELEASE_BIT = 0;
   localparam logic [15:0] RXQC_CMD_RESET = 16'h0000;
   localparam logic [15:0] RXQC_DUR_MAX = 16'hCFFF;
   localparam int RXQC_CLK_MHZ = 50;
   localparam int RXQC_US_NS = 1000;
   localparam int RXQC_CLK_NS = 20;
   localparam int RXQC_US_CYCLES = RXQC_US_NS / RXQC_CLK_NS;
   localparam int RXQC_RELEASE_CYCLES = 4;
endpackage

// file: src/rxqc_cmp.sv
// Purpose: threshold comparator with registered hit output
// Assumes: count and threshold share one width
// Notes: hit means strictly above threshold
`timescale 1ns/1ps
module rxqc_cmp #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] count,
   input wire logic [W-1:0] threshold,
   output logic hit
);
   always_ff @(posedge clk) begin
      if (rst) begin
         hit <= 1'b0;
      end else begin
         hit <= (count > threshold);
      end
   end
endmodule

// file: src/rxqc_top.sv
// Purpose: receive queue command register with threshold logic
// Assumes: host access decoded to word address, one-cycle strobes
// Notes: frame/byte events come from the receive queue logic
`timescale 1ns/1ps
module rxqc_top #(
   parameter int CNT_W = 16,
   parameter int US_CYCLES = rxqc_pkg::RXQC_US_CYCLES,
   parameter int REL_CYCLES = rxqc_pkg::RXQC_RELEASE_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_ack,
   output logic reg_refused,
   input wire logic [15:0] duration_threshold_value,
   input wire logic [15:0] byte_count_threshold_value,
   input wire logic [15:0] frame_count_threshold_value,
   input wire logic frame_in,
   input wire logic [11:0] frame_in_bytes,
   input wire logic frame_out,
   input wire logic [11:0] frame_out_bytes,
   input wire logic frame_read_done,
   output logic rx_irq_set,
   output logic ip_align_pad_enable,
   output logic dma_window,
   output logic dequeue_pulse,
   output logic release_pulse
);
   logic ip_pad_r;
   logic dur_en_r;
   logic byte_en_r;
   logic frame_en_r;
   logic auto_deq_r;
   logic dma_r;
   logic release_r;
   logic [2:0] hit_r;
   logic [CNT_W-1:0] frames_r;
   logic [CNT_W-1:0] bytes_r;
   logic [CNT_W-1:0] usec_r;
   logic [$clog2(US_CYCLES+1)-1:0] tick_r;
   logic [$clog2(REL_CYCLES+1)-1:0] rel_cnt_r;
   logic dur_hit;
   logic byte_hit;
   logic frame_hit;
   logic [15:0] dur_thr;
   logic cmd_sel;
   logic allowed;
   logic wr_cmd;
   logic isr_clr;

   // ----------------------------------------
   // Access decode
   // ----------------------------------------
   assign cmd_sel = (reg_addr == rxqc_pkg::RXQC_CMD_OFFSET);
   assign allowed = cmd_sel || !dma_r;
   assign wr_cmd = reg_wr && cmd_sel;
   assign isr_clr = reg_wr && allowed
      && (reg_addr == rxqc_pkg::RXQC_ISR_OFFSET)
      && reg_wdata[rxqc_pkg::RXQC_ISR_RX_BIT];

   // Host-writable control bits
   always_ff @(posedge clk) begin
      if (rst) begin
         ip_pad_r <= 1'b0;
         dur_en_r <= 1'b0;
         byte_en_r <= 1'b0;
         frame_en_r <= 1'b0;
         auto_deq_r <= 1'b0;
         dma_r <= 1'b0;
      end else if (wr_cmd) begin
         ip_pad_r <= reg_wdata[rxqc_pkg::RXQC_PAD_BIT];
         dur_en_r <= reg_wdata[rxqc_pkg::RXQC_DUR_EN_BIT];
         byte_en_r <= reg_wdata[rxqc_pkg::RXQC_BYTE_EN_BIT];
         frame_en_r <= reg_wdata[rxqc_pkg::RXQC_FRAME_EN_BIT];
         auto_deq_r <= reg_wdata[rxqc_pkg::RXQC_AUTO_DEQ_BIT];
         dma_r <= reg_wdata[rxqc_pkg::RXQC_DMA_BIT];
      end
   end

   // ----------------------------------------
   // Release of errored frame
   // ----------------------------------------
   // Writing zero never aborts a release already under way
   always_ff @(posedge clk) begin
      if (rst) begin
         release_r <= 1'b0;
         rel_cnt_r <= '0;
      end else if (release_r) begin
         if (rel_cnt_r == ($bits(rel_cnt_r))'(REL_CYCLES - 1)) begin
            release_r <= 1'b0;
            rel_cnt_r <= '0;
         end else begin
            rel_cnt_r <= rel_cnt_r + 1'b1;
         end
      end else if (wr_cmd && reg_wdata[rxqc_pkg::RXQC_RELEASE_BIT]) begin
         release_r <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         release_pulse <= 1'b0;
      end else begin
         release_pulse <= !release_r && wr_cmd
            && reg_wdata[rxqc_pkg::RXQC_RELEASE_BIT];
      end
   end

   // ----------------------------------------
   // Queue occupancy counters
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         frames_r <= '0;
         bytes_r <= '0;
      end else begin
         frames_r <= frames_r + CNT_W'(frame_in) - CNT_W'(frame_out);
         bytes_r <= bytes_r + CNT_W'(frame_in ? frame_in_bytes : 12'h0000)
            - CNT_W'(frame_out ? frame_out_bytes : 12'h0000);
      end
   end

   // Timer runs while any frame is buffered, restarts when queue empties
   always_ff @(posedge clk) begin
      if (rst || frames_r == '0) begin
         tick_r <= '0;
         usec_r <= '0;
      end else if (tick_r == ($bits(tick_r))'(US_CYCLES - 1)) begin
         tick_r <= '0;
         if (usec_r != '1) begin
            usec_r <= usec_r + 1'b1;
         end
      end else begin
         tick_r <= tick_r + 1'b1;
      end
   end

   // Clamp programmed value to the largest legal threshold
   assign dur_thr = (duration_threshold_value > rxqc_pkg::RXQC_DUR_MAX)
      ? rxqc_pkg::RXQC_DUR_MAX : duration_threshold_value;

   rxqc_cmp #(.W(CNT_W)) u_dur_cmp (
      .clk(clk),
      .rst(rst),
      .count(usec_r),
      .threshold(CNT_W'(dur_thr)),
      .hit(dur_hit)
   );
   rxqc_cmp #(.W(CNT_W)) u_byte_cmp (
      .clk(clk),
      .rst(rst),
      .count(bytes_r),
      .threshold(CNT_W'(byte_count_threshold_value)),
      .hit(byte_hit)
   );
   rxqc_cmp #(.W(CNT_W)) u_frame_cmp (
      .clk(clk),
      .rst(rst),
      .count(frames_r),
      .threshold(CNT_W'(frame_count_threshold_value)),
      .hit(frame_hit)
   );

   // ----------------------------------------
   // Interrupt cause and status snapshot
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_irq_set <= 1'b0;
      end else begin
         rx_irq_set <= (dur_en_r && dur_hit)
            || (byte_en_r && byte_hit)
            || (frame_en_r && frame_hit);
      end
   end

   // Status holds until the host acknowledges the receive interrupt
   always_ff @(posedge clk) begin
      if (rst) begin
         hit_r <= 3'b000;
      end else if (isr_clr) begin
         hit_r[2] <= dur_en_r && dur_hit;
         hit_r[1] <= byte_en_r && byte_hit;
         hit_r[0] <= frame_en_r && frame_hit;
      end
   end

   // ----------------------------------------
   // Dequeue and outputs
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         dequeue_pulse <= 1'b0;
         ip_align_pad_enable <= 1'b0;
         dma_window <= 1'b0;
      end else begin
         dequeue_pulse <= auto_deq_r && frame_read_done;
         ip_align_pad_enable <= ip_pad_r;
         dma_window <= dma_r;
      end
   end

   // ----------------------------------------
   // Register read
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= rxqc_pkg::RXQC_CMD_RESET;
         reg_ack <= 1'b0;
         reg_refused <= 1'b0;
      end else begin
         reg_ack <= (reg_rd || reg_wr) && allowed;
         reg_refused <= (reg_rd || reg_wr) && !allowed;
         if (reg_rd && cmd_sel) begin
            // DMA bit is write-only and reads as zero
            reg_rdata <= {3'b000, hit_r, ip_pad_r, 1'b0, dur_en_r,
               byte_en_r, frame_en_r, auto_deq_r, 1'b0, 2'b00,
               release_r};
         end else begin
            reg_rdata <= 16'h0000;
         end
      end
   end
endmodule

// file: tb/rxqc_monitor.sv
// Purpose: port checker for rxqc_top
// Assumes: writes to 0x82 are never refused
// Notes: bits 7..4 mirrored from host writes
`timescale 1ns/1ps
module rxqc_monitor (
   input wire logic clk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_ack,
   input wire logic reg_refused,
   input wire logic frame_read_done,
   input wire logic rx_irq_set,
   input wire logic ip_align_pad_enable,
   input wire logic dma_window,
   input wire logic dequeue_pulse,
   input wire logic release_pulse
);
   logic [3:0] en_r;
   logic dma_m;
   wire cmd_wr = reg_wr && reg_addr == 8'h82;
   wire acc = reg_wr || reg_rd;
   // Own window copy: the output lags two cycles behind a write
   wire blk = dma_m && reg_addr != 8'h82;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   always_ff @(posedge clk) begin
      if (rst) begin
         en_r <= 4'h0;
         dma_m <= 1'b0;
      end else if (cmd_wr) begin
         en_r <= reg_wdata[7:4];
         dma_m <= reg_wdata[3];
      end
   end
   sequence s_rel_req;
      cmd_wr && reg_wdata[0];
   endsequence
   sequence s_rel_quiet;
      !release_pulse [*4];
   endsequence
   a_ack_allowed: assert property (
      acc && !blk |=> reg_ack && !reg_refused)
      else $error("allowed access not acknowledged");
   a_refuse_blocked: assert property (
      acc && blk |=> reg_refused && !reg_ack)
      else $error("access during window not refused");
   a_dma_follow: assert property (
      cmd_wr |-> ##2 dma_window == $past(reg_wdata[3], 2))
      else $error("window does not follow bit 3");
   a_pad_follow: assert property (
      cmd_wr |-> ##2 ip_align_pad_enable == $past(reg_wdata[9], 2))
      else $error("pad enable does not follow bit 9");
   a_bit3_reads0: assert property (
      reg_rd && reg_addr == 8'h82 |=> !reg_rdata[3])
      else $error("write-only bit read back");
   a_dequeue_auto: assert property (
      dequeue_pulse == ($past(frame_read_done) && $past(en_r[0])))
      else $error("dequeue pulse wrong");
   a_release_once: assert property (
      s_rel_req ##1 release_pulse |=> s_rel_quiet)
      else $error("release pulse repeated");
   a_irq_disabled: assert property (
      (en_r[3:1] == 3'b000) [*3] |-> !rx_irq_set)
      else $error("interrupt with all enables off");
   a_reset_clear: assert property (
      $fell(rst) |-> !dma_window && !ip_align_pad_enable && !rx_irq_set)
      else $error("outputs not clear after reset");
endmodule
bind rxqc_top rxqc_monitor u_mon (.clk(clk), .rst(rst), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_refused(reg_refused),
   .frame_read_done(frame_read_done), .rx_irq_set(rx_irq_set),
   .ip_align_pad_enable(ip_align_pad_enable), .dma_window(dma_window),
   .dequeue_pulse(dequeue_pulse), .release_pulse(release_pulse));

// file: tb/rxqc_host.sv
// Purpose: host side of the register access strobes
// Assumes: one-cycle strobes, answer within four cycles
// Notes: r returns {refused, ack}, 0 on no answer
`timescale 1ns/1ps
module rxqc_host (
   input wire logic clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_ack,
   input wire logic reg_refused
);
   // Accesses that never got an answer; the bench counts them as failures
   int n_timeout;
   initial begin
      n_timeout = 0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
   end
   task automatic acc(input logic wr, input logic [7:0] a,
         input logic [15:0] d, output logic [15:0] q, output logic [1:0] r);
      int i;
      @(negedge clk);
      reg_wr = wr;
      reg_rd = !wr;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      r = 2'b00;
      q = 16'h0000;
      for (i = 0; i < 4 && r == 2'b00; i++) begin
         if (reg_ack === 1'b1 || reg_refused === 1'b1) begin
            r = {reg_refused, reg_ack};
            q = reg_rdata;
         end else begin
            @(negedge clk);
         end
      end
      if (r == 2'b00) begin
         n_timeout++;
      end
   endtask
endmodule

// file: tb/tb.sv
// Purpose: directed bench for rxqc_top
// Assumes: microsecond shortened to 2 cycles
// Notes: frame_out_bytes tied to 0x040, frame_out pulsed to empty the queue
`timescale 1ns/1ps
module tb;
   logic clk, rst, f_in, f_done, h, ack, ref_n, irq, pad, dma, deq, rel;
   logic wr, rd, f_out;
   logic [11:0] ob;
   logic [7:0] a;
   logic [15:0] wd, rdat, q;
   logic [1:0] r;
   int failures, n_tests, i, k;
   rxqc_top #(.US_CYCLES(2)) DUT (.clk(clk), .rst(rst), .reg_wr(wr),
      .reg_rd(rd), .reg_addr(a), .reg_wdata(wd), .reg_rdata(rdat),
      .reg_ack(ack), .reg_refused(ref_n),
      .duration_threshold_value(16'h0003),
      .byte_count_threshold_value(16'h0010),
      .frame_count_threshold_value(16'h0000), .frame_in(f_in),
      .frame_in_bytes(12'h040), .frame_out(f_out), .frame_out_bytes(ob),
      .frame_read_done(f_done), .rx_irq_set(irq), .ip_align_pad_enable(pad),
      .dma_window(dma), .dequeue_pulse(deq), .release_pulse(rel));
   rxqc_host host (.clk(clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(a),
      .reg_wdata(wd), .reg_rdata(rdat), .reg_ack(ack), .reg_refused(ref_n));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Bounded wait for a level or pulse, sampled at falling edges
   task automatic wait_hi(ref logic s, input int lim);
      h = 1'b0;
      for (int j = 0; j < lim && !h; j++) begin
         if (s === 1'b1) h = 1'b1;
         else @(negedge clk);
      end
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask
   task automatic summarize;
      $display("compares %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      f_in = 1'b0;
      f_done = 1'b0;
      f_out = 1'b0;
      ob = 12'h040;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      host.acc(1'b0, 8'h82, 16'h0000, q, r);
      check(q, 16'h0000);
      host.acc(1'b1, 8'h82, 16'hE3F6, q, r);
      host.acc(1'b0, 8'h82, 16'h0000, q, r);
      check(q, 16'h02F0);
      check({15'h0000, pad}, 16'h0001);
      $display("layout test done");
      pulse(f_done);
      wait_hi(deq, 3);
      check({15'h0000, h}, 16'h0001);
      host.acc(1'b1, 8'h82, 16'h02E1, q, r);
      check({15'h0000, rel}, 16'h0001);
      host.acc(1'b0, 8'h82, 16'h0000, q, r);
      check(q, 16'h02E1);
      for (i = 0; i < 10 && q[0] !== 1'b0; i++) begin
         host.acc(1'b0, 8'h82, 16'h0000, q, r);
      end
      check(q, 16'h02E0);
      pulse(f_done);
      wait_hi(deq, 3);
      check({15'h0000, h}, 16'h0000);
      $display("dequeue and release test done");
      for (k = 0; k < 3; k++) begin
         host.acc(1'b1, 8'h82, 16'h0020 << k, q, r);
         pulse(f_in);
         wait_hi(irq, 400);
         check({15'h0000, h}, 16'h0001);
         host.acc(1'b0, 8'h82, 16'h0000, q, r);
         check(q, (16'h0020 << k) | ((16'h0200 << k) & 16'h1C00));
         host.acc(1'b1, 8'h92, 16'h2000, q, r);
         host.acc(1'b0, 8'h82, 16'h0000, q, r);
         check(q, (16'h0020 << k) | (16'h0400 << k));
      end
      // Empty the queue: timer restarts, duration interrupt drops
      for (k = 0; k < 3; k++) begin
         pulse(f_out);
      end
      repeat (5) @(negedge clk);
      check({15'h0000, irq}, 16'h0000);
      $display("threshold test done");
      host.acc(1'b1, 8'h86, 16'h0000, q, r);
      host.acc(1'b1, 8'h82, 16'h0008, q, r);
      @(negedge clk);
      check({15'h0000, dma}, 16'h0001);
      host.acc(1'b0, 8'h92, 16'h0000, q, r);
      check({14'h0000, r}, 16'h0002);
      host.acc(1'b1, 8'h92, 16'h2000, q, r);
      check({14'h0000, r}, 16'h0002);
      host.acc(1'b0, 8'h82, 16'h0000, q, r);
      check(q, 16'h1000);
      host.acc(1'b1, 8'h82, 16'h0000, q, r);
      host.acc(1'b0, 8'h92, 16'h0000, q, r);
      check({14'h0000, r}, 16'h0001);
      $display("window test done");
      check(16'(host.n_timeout), 16'h0000);
      summarize();
   end
endmodule
